/* design/nest_if.sv */
`default_nettype none
interface nest_if;
    logic push;
    logic pop;
    logic [8:0] push_num;
    logic [3:0] push_lvl;
    logic [8:0] top_num;
    logic [3:0] top_lvl;
    logic [8:0] below_num;
    logic [3:0] count;
    modport ctrl (
        output push, pop, push_num, push_lvl,
        input top_num, top_lvl, below_num, count
    );
    modport stack (
        input push, pop, push_num, push_lvl,
        output top_num, top_lvl, below_num, count
    );
endinterface : nest_if
`default_nettype wire

/* design/nest_prio_params.svh */
`ifndef NEST_PRIO_PARAMS_SVH
`define NEST_PRIO_PARAMS_SVH
// line counts, widths and depths
`define SMALL_LINES 16
`define SMALL_PINS 8
`define LARGE_LINES 175
`define SMALL_DEPTH 4
`define LARGE_DEPTH 8
`define LINE_EXC_BASE 16
// fixed exception numbers
`define EXC_NUM_NMI 9'h002
`define EXC_NUM_HARD_FAULT 9'h003
// internal urgency levels, smaller is more urgent
`define LVL_RESET 4'h0
`define LVL_NMI 4'h1
`define LVL_HARD_FAULT 4'h2
`define LVL_CFG_BASE 4'h3
`define LVL_THREAD 4'hf
// byte offsets inside one core window
`define CORE_SEL_BIT 10
`define GROUP_MASK 10'h3e0
`define PRIO_MASK 10'h300
`define OFF_ENABLE_SET 10'h000
`define OFF_ENABLE_CLEAR 10'h020
`define OFF_PENDING_SET 10'h040
`define OFF_PENDING_CLEAR 10'h060
`define OFF_CONTROL_STATE 10'h080
`define OFF_PRIORITY_MASK 10'h084
`define OFF_PRIORITY 10'h100
// control/state and mask fields
`define CS_ACTIVE_LSB 0
`define CS_PENDING_LSB 12
`define CS_ANY_PENDING_BIT 22
`define GLOBAL_MASK_BIT 0
`endif

/* design/nest_prio_pkg.sv */
`include "nest_prio_params.svh"
`default_nettype none
package nest_prio_pkg;
    // one nesting level: exception number and its urgency
    typedef struct packed {
        logic [8:0] num;
        logic [3:0] lvl;
    } stack_ent_s;
    // complete state of the controller top
    typedef struct packed {
        logic [1:0][`LARGE_LINES-1:0] en;
        logic [1:0][`LARGE_LINES-1:0] pend;
        logic [1:0][`LARGE_LINES-1:0] act;
        logic [1:0][`LARGE_LINES-1:0][2:0] prio;
        logic [1:0][`LARGE_LINES-1:0] prev;
        logic [1:0][1:0] fpend;
        logic [1:0][1:0] fact;
        logic [1:0] pmask;
        logic [1:0] req;
        logic [1:0][8:0] req_num;
        logic [1:0][3:0] req_lvl;
        logic [1:0][8:0] act_num;
        logic [`SMALL_PINS-1:0] s_ff1;
        logic [`SMALL_PINS-1:0] s_ff2;
        logic [`LARGE_LINES-1:0] l_ff1;
        logic [`LARGE_LINES-1:0] l_ff2;
        logic waitreq;
        logic [31:0] rdata;
    } ctrl_state_s;
endpackage : nest_prio_pkg
`default_nettype wire

/* design/nest_stack.sv */
`include "nest_prio_params.svh"
`default_nettype none
module nest_stack
    import nest_prio_pkg::*;
#(
    parameter int DEPTH = 4
)
(
    input wire logic mclk_i, // core clock
    input wire logic rst_i, // sync reset, high
    nest_if.stack nest // push/pop port
);
    typedef struct packed {
        stack_ent_s [DEPTH-1:0] ent;
        logic [3:0] cnt;
    } stack_state_s;

    stack_state_s st_reg;
    stack_state_s st_next;
    stack_ent_s top;
    logic [8:0] below;

    // top and second entry; pop before push so both replace the top
    always_comb
    begin
        st_next = st_reg;
        top = '{num: 9'h000, lvl: `LVL_THREAD};
        below = 9'h000;
        for (int i = 0; i < DEPTH; i++)
        begin
            if (4'(i + 1) == st_reg.cnt)
                top = st_reg.ent[i];
            if (4'(i + 2) == st_reg.cnt)
                below = st_reg.ent[i].num;
        end
        if (nest.pop && st_reg.cnt != 4'h0)
            st_next.cnt = st_reg.cnt - 4'h1;
        if (nest.push && st_next.cnt < 4'(DEPTH))
        begin
            for (int i = 0; i < DEPTH; i++)
                if (4'(i) == st_next.cnt)
                    st_next.ent[i] = '{num: nest.push_num, lvl: nest.push_lvl};
            st_next.cnt = st_next.cnt + 4'h1;
        end
    end

    // state register
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign nest.top_num = top.num;
    assign nest.top_lvl = top.lvl;
    assign nest.below_num = below;
    assign nest.count = st_reg.cnt;
endmodule : nest_stack
`default_nettype wire

/* design/nested_interrupt_prio_ctrl.sv */
// The implementer's own choices: the Avalon-MM slave port and the register addresses.
`include "nest_prio_params.svh"
`default_nettype none
module nested_interrupt_prio_ctrl
    import nest_prio_pkg::*;
(
    input wire logic mclk_i, // core clock, 250 MHz
    input wire logic rst_i, // sync reset, high
    input wire logic [11:0] address_i, // avalon byte address
    input wire logic read_i, // avalon read
    input wire logic write_i, // avalon write
    input wire logic [31:0] writedata_i, // avalon write data
    output logic [31:0] readdata_o, // avalon read data
    output logic waitrequest_o, // avalon wait
    input wire logic [`SMALL_PINS-1:0] irq_small_i, // small core lines
    input wire logic [`LARGE_LINES-1:0] irq_large_i, // large core lines
    input wire logic [1:0] nmi_i, // nmi event, [0] small
    input wire logic [1:0] hard_fault_i, // fault event
    input wire logic [1:0] entry_i, // handler start pulse
    input wire logic [1:0] exit_i, // handler return pulse
    output logic [1:0] req_o, // exception request
    output logic [1:0][8:0] req_num_o, // requested number
    output logic [1:0][8:0] active_num_o // running number
);
    localparam ctrl_state_s ST_RESET = '{waitreq: 1'b1, default: '0};

    ctrl_state_s st_reg;
    ctrl_state_s st_next;
    logic [1:0][`LARGE_LINES-1:0] lines;
    logic [1:0] push;
    logic [1:0] pop;
    logic [1:0][8:0] push_num;
    logic [1:0][3:0] push_lvl;
    logic [1:0][8:0] tn;
    logic [1:0][3:0] tl;
    logic [1:0][8:0] bn;
    logic [1:0][3:0] tc;
    logic [9:0] off;
    logic wr_go;
    logic [31:0] rd;
    logic [3:0] lv;
    logic [3:0] cbest_lvl;
    logic [8:0] cbest_num;
    logic fx_ok;
    logic [8:0] fx_num;
    logic [3:0] fx_lvl;
    logic cand_ok;
    logic [8:0] cand_num;
    logic [3:0] cand_lvl;
    logic entering;
    logic leaving;
    int n;
    int depth;
    int l;
    int gk;
    int pidx;
    int li;

    nest_if nest_small ();
    nest_if nest_large ();

    // nesting stacks, one per core
    nest_stack #(.DEPTH(`SMALL_DEPTH)) u_stack_small (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .nest(nest_small)
    );
    nest_stack #(.DEPTH(`LARGE_DEPTH)) u_stack_large (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .nest(nest_large)
    );

    // stack hookup
    assign nest_small.push = push[0];
    assign nest_small.pop = pop[0];
    assign nest_small.push_num = push_num[0];
    assign nest_small.push_lvl = push_lvl[0];
    assign nest_large.push = push[1];
    assign nest_large.pop = pop[1];
    assign nest_large.push_num = push_num[1];
    assign nest_large.push_lvl = push_lvl[1];
    assign tn = {nest_large.top_num, nest_small.top_num};
    assign tl = {nest_large.top_lvl, nest_small.top_lvl};
    assign bn = {nest_large.below_num, nest_small.below_num};
    assign tc = {nest_large.count, nest_small.count};

    // whole controller next state
    always_comb
    begin
        st_next = st_reg;
        rd = 32'h0000_0000;
        push = '0;
        pop = '0;
        push_num = '0;
        push_lvl = '0;
        lv = 4'h0;
        cbest_lvl = `LVL_THREAD;
        cbest_num = 9'h000;
        fx_ok = 1'b0;
        fx_num = 9'h000;
        fx_lvl = `LVL_THREAD;
        cand_ok = 1'b0;
        cand_num = 9'h000;
        cand_lvl = `LVL_THREAD;
        entering = 1'b0;
        leaving = 1'b0;
        n = 0;
        depth = 0;
        l = 0;
        li = 0;
        off = address_i[9:0];
        gk = int'(off[4:2]);
        pidx = int'(off[7:2]);
        wr_go = write_i && !st_reg.waitreq && !address_i[11];
        // pin synchronisers, second stage only is read
        st_next.s_ff1 = irq_small_i;
        st_next.s_ff2 = st_reg.s_ff1;
        st_next.l_ff1 = irq_large_i;
        st_next.l_ff2 = st_reg.l_ff1;
        lines[0] = {{(`LARGE_LINES - `SMALL_PINS){1'b0}}, st_reg.s_ff2};
        lines[1] = st_reg.l_ff2;
        for (int c = 0; c < 2; c++)
        begin
            n = (c == 1) ? `LARGE_LINES : `SMALL_LINES;
            depth = (c == 1) ? `LARGE_DEPTH : `SMALL_DEPTH;
            li = -1;
            // most urgent enabled pending line, strict compare keeps lowest number
            cbest_lvl = `LVL_THREAD;
            cbest_num = 9'h000;
            for (int i = 0; i < `LARGE_LINES; i++)
            begin
                if (i < n && st_reg.pend[c][i] && st_reg.en[c][i])
                begin
                    lv = 4'(st_reg.prio[c][i]) + `LVL_CFG_BASE;
                    if (lv < cbest_lvl)
                    begin
                        cbest_lvl = lv;
                        cbest_num = 9'(i + `LINE_EXC_BASE);
                    end
                end
            end
            // fixed-level events beat every configurable level
            fx_ok = |st_reg.fpend[c];
            fx_num = st_reg.fpend[c][0] ? `EXC_NUM_NMI : `EXC_NUM_HARD_FAULT;
            fx_lvl = st_reg.fpend[c][0] ? `LVL_NMI : `LVL_HARD_FAULT;
            // global mask holds back configurable exceptions only
            cand_ok = fx_ok || (cbest_lvl != `LVL_THREAD && !st_reg.pmask[c]);
            cand_num = fx_ok ? fx_num : cbest_num;
            cand_lvl = fx_ok ? fx_lvl : cbest_lvl;
            entering = entry_i[c] && st_reg.req[c];
            leaving = exit_i[c] && tc[c] != 4'h0;
            // request only when strictly more urgent and nesting room left
            st_next.req[c] = cand_ok && cand_lvl < tl[c]
                && int'(tc[c]) < depth && !entering;
            st_next.req_num[c] = cand_num;
            st_next.req_lvl[c] = cand_lvl;
            // register reads for the addressed core
            if (int'(address_i[`CORE_SEL_BIT]) == c)
            begin
                if ((off & `GROUP_MASK) == `OFF_ENABLE_SET || (off & `GROUP_MASK) == `OFF_ENABLE_CLEAR)
                begin
                    for (int i = 0; i < 32; i++)
                    begin
                        l = gk * 32 + i;
                        if (l < n)
                            rd[i] = st_reg.en[c][l];
                    end
                end
                if ((off & `GROUP_MASK) == `OFF_PENDING_SET || (off & `GROUP_MASK) == `OFF_PENDING_CLEAR)
                begin
                    for (int i = 0; i < 32; i++)
                    begin
                        l = gk * 32 + i;
                        if (l < n)
                            rd[i] = st_reg.pend[c][l];
                    end
                end
                if (off == `OFF_CONTROL_STATE)
                begin
                    rd[`CS_ACTIVE_LSB +: 9] = st_reg.act_num[c];
                    rd[`CS_PENDING_LSB +: 9] = fx_ok ? fx_num : cbest_num;
                    rd[`CS_ANY_PENDING_BIT] = |st_reg.pend[c];
                end
                if (off == `OFF_PRIORITY_MASK)
                    rd[`GLOBAL_MASK_BIT] = st_reg.pmask[c];
                if ((off & `PRIO_MASK) == `OFF_PRIORITY)
                begin
                    for (int j = 0; j < 4; j++)
                    begin
                        l = pidx * 4 + j;
                        if (l < n && c == 1)
                            rd[8 * j + 5 +: 3] = st_reg.prio[c][l];
                        else if (l < n)
                            rd[8 * j + 6 +: 2] = st_reg.prio[c][l][1:0];
                    end
                end
            end
            // register writes; in the set and clear groups ones act and zeros are ignored
            if (wr_go && int'(address_i[`CORE_SEL_BIT]) == c)
            begin
                for (int i = 0; i < 32; i++)
                begin
                    l = gk * 32 + i;
                    if (l < n && writedata_i[i])
                    begin
                        if ((off & `GROUP_MASK) == `OFF_ENABLE_SET)
                            st_next.en[c][l] = 1'b1;
                        if ((off & `GROUP_MASK) == `OFF_ENABLE_CLEAR)
                            st_next.en[c][l] = 1'b0;
                        if ((off & `GROUP_MASK) == `OFF_PENDING_SET)
                            st_next.pend[c][l] = 1'b1;
                        if ((off & `GROUP_MASK) == `OFF_PENDING_CLEAR)
                            st_next.pend[c][l] = 1'b0;
                    end
                end
                if (off == `OFF_PRIORITY_MASK)
                    st_next.pmask[c] = writedata_i[`GLOBAL_MASK_BIT];
                if ((off & `PRIO_MASK) == `OFF_PRIORITY)
                begin
                    for (int j = 0; j < 4; j++)
                    begin
                        l = pidx * 4 + j;
                        if (l < n && c == 1)
                            st_next.prio[c][l] = writedata_i[8 * j + 5 +: 3];
                        else if (l < n)
                            st_next.prio[c][l] = {1'b0, writedata_i[8 * j + 6 +: 2]};
                    end
                end
            end
            // handler return: pop back to the interrupted handler
            if (leaving)
            begin
                pop[c] = 1'b1;
                if (tn[c] == `EXC_NUM_NMI)
                    st_next.fact[c][0] = 1'b0;
                else if (tn[c] == `EXC_NUM_HARD_FAULT)
                    st_next.fact[c][1] = 1'b0;
                else if (tn[c] >= 9'(`LINE_EXC_BASE))
                    st_next.act[c][int'(tn[c]) - `LINE_EXC_BASE] = 1'b0;
                st_next.act_num[c] = (tc[c] > 4'h1) ? bn[c] : 9'h000;
            end
            // handler start: pending becomes active
            if (entering)
            begin
                push[c] = 1'b1;
                push_num[c] = st_reg.req_num[c];
                push_lvl[c] = st_reg.req_lvl[c];
                st_next.act_num[c] = st_reg.req_num[c];
                if (st_reg.req_num[c] == `EXC_NUM_NMI)
                begin
                    st_next.fpend[c][0] = 1'b0;
                    st_next.fact[c][0] = 1'b1;
                end
                else if (st_reg.req_num[c] == `EXC_NUM_HARD_FAULT)
                begin
                    st_next.fpend[c][1] = 1'b0;
                    st_next.fact[c][1] = 1'b1;
                end
                else
                begin
                    li = int'(st_reg.req_num[c]) - `LINE_EXC_BASE;
                    if (li >= 0 && li < n)
                    begin
                        st_next.pend[c][li] = 1'b0;
                        st_next.act[c][li] = 1'b1;
                    end
                end
            end
            // a pending-set write landing on the entry cycle still leaves the line pending
            if (entering && li >= 0 && li < n && wr_go && int'(address_i[`CORE_SEL_BIT]) == c
                && (off & `GROUP_MASK) == `OFF_PENDING_SET && gk == li / 32 && writedata_i[li % 32])
                st_next.pend[c][li] = 1'b1;
            // line requests set pending last, so a set beats any clear
            for (int i = 0; i < `LARGE_LINES; i++)
            begin
                if (i < n && st_reg.en[c][i] && lines[c][i])
                begin
                    // level while idle; a new edge while active gives active and pending
                    if (!st_reg.act[c][i] && !(entering && li == i))
                        st_next.pend[c][i] = 1'b1;
                    else if (!st_reg.prev[c][i])
                        st_next.pend[c][i] = 1'b1;
                end
            end
            st_next.prev[c] = lines[c];
            // fixed events pend after any clear in this cycle
            if (nmi_i[c])
                st_next.fpend[c][0] = 1'b1;
            if (hard_fault_i[c])
                st_next.fpend[c][1] = 1'b1;
        end
        // avalon slave: one wait cycle, read data captured as wait drops
        st_next.waitreq = 1'b1;
        if ((read_i || write_i) && st_reg.waitreq)
        begin
            st_next.waitreq = 1'b0;
            st_next.rdata = address_i[11] ? 32'h0000_0000 : rd;
        end
    end

    // state register
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            st_reg <= ST_RESET;
        else
            st_reg <= st_next;
    end

    // outputs straight from flops
    assign readdata_o = st_reg.rdata;
    assign waitrequest_o = st_reg.waitreq;
    assign req_o = st_reg.req;
    assign req_num_o = st_reg.req_num;
    assign active_num_o = st_reg.act_num;
endmodule : nested_interrupt_prio_ctrl
`default_nettype wire

/* dv/core_model.sv */
`default_nettype none
module core_model
#(
    parameter int LAT = 0
)
(
    input wire logic mclk_i, // core clock
    input wire logic rst_i, // sync reset
    input wire logic req_i, // exception request
    output logic entry_o // handler start pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    // takes a request after LAT waiting cycles, one pulse per request
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            cnt <= 0;
            entry_o <= 1'b0;
        end
        else
        begin
            entry_o <= 1'b0;
            if (req_i && !entry_o && cnt >= LAT)
            begin
                entry_o <= 1'b1;
                cnt <= 0;
            end
            else if (req_i && !entry_o)
                cnt <= cnt + 1;
            else
                cnt <= 0;
        end
    end
endmodule : core_model
`default_nettype wire

/* dv/nest_prio_checker_assertions.sv */
`include "nest_prio_params.svh"
`default_nettype none
module nest_prio_checker
(
    input wire logic mclk_i, // clock
    input wire logic rst_i, // reset
    input wire logic [11:0] address_i, // address
    input wire logic read_i, // read
    input wire logic write_i, // write
    input wire logic [31:0] writedata_i, // wdata
    input wire logic [31:0] readdata_o, // rdata
    input wire logic waitrequest_o, // wait
    input wire logic [`SMALL_PINS-1:0] irq_small_i, // lines
    input wire logic [`LARGE_LINES-1:0] irq_large_i, // lines
    input wire logic [1:0] nmi_i, // nmi
    input wire logic [1:0] hard_fault_i, // fault
    input wire logic [1:0] entry_i, // entry
    input wire logic [1:0] exit_i, // exit
    input wire logic [1:0] req_o, // request
    input wire logic [1:0][8:0] req_num_o, // number
    input wire logic [1:0][8:0] active_num_o // running
);
    timeunit 1ns;
    timeprecision 1ps;
    logic mask_reg;
    logic mask_dly_reg;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    // small core global mask as written, plus one cycle of age
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            mask_reg <= 1'b0;
            mask_dly_reg <= 1'b0;
        end
        else
        begin
            if (write_i && !waitrequest_o && address_i == 12'h084)
                mask_reg <= writedata_i[0];
            mask_dly_reg <= mask_reg;
        end
    end
    wait_answer_a:
    assert property ((read_i || write_i) && waitrequest_o |=> !waitrequest_o) else $error("bus not answered");
    wait_single_a:
    assert property (!waitrequest_o |=> waitrequest_o) else $error("wait low too long");
    entry_small_a:
    assert property (entry_i[0] && req_o[0] |=> !req_o[0] && active_num_o[0] == $past(req_num_o[0]))
        else $error("small entry not taken");
    entry_large_a:
    assert property (entry_i[1] && req_o[1] |=> active_num_o[1] == $past(req_num_o[1])) else $error("large entry");
    exit_return_a:
    assert property (exit_i[0] && !entry_i[0] && active_num_o[0] != 9'h000 |=>
        active_num_o[0] != $past(active_num_o[0])) else $error("exit did not return");
    active_hold_a:
    assert property (!entry_i[0] && !exit_i[0] |=> $stable(active_num_o[0])) else $error("active changed");
    no_self_a:
    assert property (req_o[0] |-> req_num_o[0] != active_num_o[0]) else $error("self preemption");
    mask_block_a:
    assert property (mask_reg && mask_dly_reg && req_o[0] |-> req_num_o[0] < 9'h010) else $error("mask ignored");
    nmi_take_a:
    assert property (nmi_i[0] && active_num_o[0] != 9'h002 |-> ##[1:4] (req_o[0] && req_num_o[0] == 9'h002))
        else $error("nmi not requested");
    fault_take_a:
    assert property (hard_fault_i[0] && active_num_o[0] > 9'h003 |-> ##[1:4] (req_o[0] && req_num_o[0] == 9'h003))
        else $error("fault not requested");
    cover property (active_num_o[0] == 9'h002);
    cover property (active_num_o[1] == 9'h0be);
    cover property (mask_dly_reg && !req_o[0]);
endmodule : nest_prio_checker
bind nested_interrupt_prio_ctrl nest_prio_checker nest_prio_checker_inst (.mclk_i, .rst_i, .address_i, .read_i,
    .write_i, .writedata_i, .readdata_o, .waitrequest_o, .irq_small_i, .irq_large_i, .nmi_i, .hard_fault_i,
    .entry_i, .exit_i, .req_o, .req_num_o, .active_num_o);
`default_nettype wire

/* dv/nested_interrupt_prio_ctrl_tb.sv */
`include "nest_prio_params.svh"
`default_nettype none
module nested_interrupt_prio_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [11:0] wa; logic [31:0] wd; logic [11:0] ra; logic [31:0] ex;} row_s;
    logic mclk_i, rst_i, read_i, write_i, waitrequest_o;
    logic [11:0] address_i;
    logic [31:0] writedata_i, readdata_o, q;
    logic [`SMALL_PINS-1:0] irq_small_i;
    logic [`LARGE_LINES-1:0] irq_large_i;
    logic [1:0] nmi_i, hard_fault_i, exit_i, req_o;
    wire [1:0] entry_i;
    logic [1:0][8:0] req_num_o, active_num_o;
    int n_fail = 0;
    int total_checks = 0;
    row_s rows [9] = '{
        '{12'h000, 32'h0001_0005, 12'h000, 32'h0000_0005},
        '{12'h020, 32'h0000_0001, 12'h020, 32'h0000_0004},
        '{12'h100, 32'hffff_ffff, 12'h100, 32'hc0c0_c0c0},
        '{12'h500, 32'hffff_ffff, 12'h500, 32'he0e0_e0e0},
        '{12'h800, 32'hffff_ffff, 12'h800, 32'h0000_0000},
        '{12'h040, 32'h0000_0100, 12'h080, 32'h0040_0000},
        '{12'h060, 32'h0000_0100, 12'h040, 32'h0000_0000},
        '{12'h414, 32'h0000_7fff, 12'h434, 32'h0000_7fff},
        '{12'h540, 32'h0000_0000, 12'h540, 32'h0000_0000}};
    nested_interrupt_prio_ctrl nested_interrupt_prio_ctrl_inst (.mclk_i, .rst_i, .address_i, .read_i, .write_i,
        .writedata_i, .readdata_o, .waitrequest_o, .irq_small_i, .irq_large_i, .nmi_i, .hard_fault_i, .entry_i,
        .exit_i, .req_o, .req_num_o, .active_num_o);
    core_model #(.LAT(0)) core_model_small_inst (.mclk_i, .rst_i, .req_i(req_o[0]), .entry_o(entry_i[0]));
    core_model #(.LAT(3)) core_model_large_inst (.mclk_i, .rst_i, .req_i(req_o[1]), .entry_o(entry_i[1]));
    // free running core clock
    initial
    begin
        mclk_i = 1'b0;
        forever #2 mclk_i = ~mclk_i;
    end
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // one avalon access, held until wait is seen low
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd);
        int n;
        address_i <= a;
        writedata_i <= d;
        write_i <= wr;
        read_i <= !wr;
        n = 0;
        do
        begin
            @(posedge mclk_i);
            n++;
        end
        while (waitrequest_o !== 1'b0 && n < 50);
        rd = readdata_o;
        read_i <= 1'b0;
        write_i <= 1'b0;
        @(posedge mclk_i);
        if (n >= 50)
        begin
            n_fail++;
            wrap_up();
        end
    endtask : bus
    task automatic wait_act(input int c, input logic [8:0] num);
        int n;
        n = 0;
        while (active_num_o[c] !== num && n < 200)
        begin
            @(posedge mclk_i);
            n++;
        end
        chk({23'h0, active_num_o[c]}, {23'h0, num});
        if (n >= 200)
            wrap_up();
    endtask : wait_act
    task automatic ret(input int c);
        exit_i <= (c == 1) ? 2'b10 : 2'b01;
        @(posedge mclk_i);
        exit_i <= 2'b00;
        @(posedge mclk_i);
    endtask : ret
    // main sequence
    initial
    begin
        rst_i = 1'b1;
        {read_i, write_i, address_i, writedata_i} = '0;
        {irq_small_i, irq_large_i, nmi_i, hard_fault_i, exit_i} = '0;
        repeat (3) @(posedge mclk_i);
        rst_i <= 1'b0;
        @(posedge mclk_i);
        foreach (rows[i])
        begin
            bus(1'b1, rows[i].wa, rows[i].wd, q);
            bus(1'b0, rows[i].ra, 32'h0000_0000, q);
            chk(q, rows[i].ex);
        end
        bus(1'b1, 12'h084, 32'h0000_0001, q);
        bus(1'b1, 12'h100, 32'h0040_4080, q);
        bus(1'b1, 12'h000, 32'h0000_000f, q);
        irq_small_i[4] <= 1'b1;
        bus(1'b1, 12'h040, 32'h0000_0006, q);
        bus(1'b1, 12'h040, 32'h0000_0006, q);
        bus(1'b0, 12'h040, 32'h0000_0000, q);
        chk(q, 32'h0000_0006);
        bus(1'b0, 12'h080, 32'h0000_0000, q);
        chk(q, 32'h0041_1000);
        chk({31'h0, req_o[0]}, 32'h0000_0000);
        bus(1'b1, 12'h084, 32'h0000_0000, q);
        wait_act(0, 9'h011);
        repeat (10) @(posedge mclk_i);
        chk({23'h0, active_num_o[0]}, 32'h0000_0011);
        bus(1'b1, 12'h040, 32'h0000_0008, q);
        wait_act(0, 9'h013);
        hard_fault_i[0] <= 1'b1;
        @(posedge mclk_i);
        hard_fault_i[0] <= 1'b0;
        wait_act(0, 9'h003);
        nmi_i[0] <= 1'b1;
        @(posedge mclk_i);
        nmi_i[0] <= 1'b0;
        wait_act(0, 9'h002);
        ret(0);
        wait_act(0, 9'h003);
        ret(0);
        wait_act(0, 9'h013);
        ret(0);
        wait_act(0, 9'h011);
        ret(0);
        wait_act(0, 9'h012);
        ret(0);
        wait_act(0, 9'h000);
        repeat (10) @(posedge mclk_i);
        chk({23'h0, active_num_o[0]}, 32'h0000_0000);
        irq_large_i[174] <= 1'b1;
        wait_act(1, 9'h0be);
        irq_large_i[174] <= 1'b0;
        repeat (4) @(posedge mclk_i);
        irq_large_i[174] <= 1'b1;
        repeat (4) @(posedge mclk_i);
        irq_large_i[174] <= 1'b0;
        bus(1'b0, 12'h454, 32'h0000_0000, q);
        chk(q, 32'h0000_4000);
        ret(1);
        wait_act(1, 9'h0be);
        repeat (4) @(posedge mclk_i);
        ret(1);
        wait_act(1, 9'h000);
        rst_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        rst_i <= 1'b0;
        @(posedge mclk_i);
        bus(1'b0, 12'h434, 32'h0000_0000, q);
        chk(q, 32'h0000_0000);
        bus(1'b0, 12'h100, 32'h0000_0000, q);
        chk(q, 32'h0000_0000);
        wrap_up();
    end
endmodule : nested_interrupt_prio_ctrl_tb
`default_nettype wire
